// >>> rtl/sfec_pkg.sv
/*
 * sfec_pkg: opcodes, timing constants and widths for the serial flash
 * erase, sleep and identification command logic.
 * assumes the logic runs on a 250 MHz clock.
 */
package sfec_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 4;
    // opcodes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS   = 8'h05;
    localparam logic [7:0] OP_ERASE_32K     = 8'h52;
    localparam logic [7:0] OP_ERASE_64K     = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
    localparam logic [7:0] OP_DEEP_SLEEP    = 8'hB9;
    localparam logic [7:0] OP_WAKE_AND_ID   = 8'hAB;
    localparam logic [7:0] OP_MAKER_PART_ID = 8'h90;
    localparam logic [7:0] OP_THREE_BYTE_ID = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID     = 8'h4B;
    // command boundaries in serial clock rising edges
    localparam logic [11:0] OPCODE_BITS  = 12'h008;
    localparam logic [11:0] ADDR_END     = 12'h020;
    localparam logic [11:0] CNT_MAX      = 12'hFFF;
    // first output byte of each reading command
    localparam logic [8:0] STATUS_START  = 9'h001;
    localparam logic [8:0] WAKE_ID_START = 9'h004;
    localparam logic [8:0] MAKER_START   = 9'h004;
    localparam logic [8:0] THREE_START   = 9'h001;
    localparam logic [8:0] UNIQUE_START  = 9'h005;
    // array and block geometry
    localparam logic [23:0] ARRAY_BYTES  = 24'h02_0000;
    localparam logic [23:0] ARRAY_MASK   = 24'h01_FFFF;
    localparam logic [23:0] BLK32_MASK   = 24'hFF_8000;
    localparam logic [23:0] BLK64_MASK   = 24'hFF_0000;
    // short delays, rounded up to whole cycles
    localparam int SLEEP_ENTRY_DELAY_NS   = 3000;
    localparam int WAKE_DELAY_NS          = 3000;
    localparam int WAKE_WITH_ID_DELAY_NS  = 3000;
    localparam logic [15:0] SLEEP_ENTRY_CYC =
        16'((SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_CYC =
        16'((WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_ID_CYC =
        16'((WAKE_WITH_ID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // erase kinds
    localparam logic [1:0] KIND_32K  = 2'h1;
    localparam logic [1:0] KIND_64K  = 2'h2;
    localparam logic [1:0] KIND_CHIP = 2'h3;
    // power states
    typedef enum logic [3:0] {
        ST_AWAKE    = 4'b0001,
        ST_ENTERING = 4'b0010,
        ST_ASLEEP   = 4'b0100,
        ST_WAKING   = 4'b1000
    } sfec_pwr_type;
endpackage

// >>> rtl/sfec_core.sv
/*
 * sfec_core: flash-side command decoder for block and chip erase, deep
 * sleep, wake and identification reads over the serial link.
 * assumes select, serial clock and data in come from outside the clock
 * domain; the serial clock is far slower than the 250 MHz clock.
 */
// Operation
// - 52h plus 3 address bytes erases a 32KB block if latch set.
// - D8h plus 3 address bytes erases a 64KB block if latch set.
// - block erase ignores address bits below the block size.
// - block erase runs only if select rises right after 32 bits.
// - valid end starts timed erase; progress flag high until done.
// - write enable latch is cleared during each erase cycle.
// - no block erase inside the protected region.
// - 60h or C7h alone, select after 8 bits, erases the array.
// - full erase only when all block protect bits are zero.
// - B9h ended after 8 bits enters deep sleep after a delay.
// - in deep sleep everything except ABh is ignored.
// - deep sleep request refused while a cycle runs.
// - power loss ends deep sleep; start-up is standby.
// - ABh releases sleep; no command accepted until delay passes.
// - ABh plus 3 dummy bytes streams device id, repeating.
// - ABh ignored while progress flag is set.
// - 90h plus address streams maker then part id, order by A0.
// - 9Fh streams maker id, memory type, then capacity.
// - 9Fh not decoded during a cycle; host avoids it when asleep.
// - select high ends 9Fh and returns to standby.
// - 4Bh plus address and dummy streams the 128-bit unique id.
// - opcode and address sampled on serial clock rising edges.
// - 05h returns the eight status bits for polling.
`timescale 1ns/100ps
`default_nettype none
module sfec_core #(
    parameter int             BLOCK_ERASE_TIME_US = 2000,
    parameter int             FULL_ERASE_TIME_US  = 8000,
    parameter logic [7:0]     MAKER_ID  = 8'h5A,             // arbitrary
    parameter logic [7:0]     PART_ID   = 8'h11,             // arbitrary
    parameter logic [7:0]     MEM_TYPE  = 8'h22,             // arbitrary
    parameter logic [7:0]     CAPACITY  = 8'h11,             // arbitrary
    parameter logic [127:0]   UNIQUE_ID = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978 // arbitrary
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_cs_n,
    input  wire logic         i_sclk,
    input  wire logic         i_si,
    input  wire logic [2:0]   i_block_protect,
    output logic              o_so,
    output logic              o_so_oe_n,
    output logic              o_write_in_progress_flag,
    output logic              o_write_enable_latch,
    output logic              o_deep_sleep,
    output logic              o_erase_start,
    output logic [1:0]        o_erase_kind,
    output logic [23:0]       o_erase_base
);
    import sfec_pkg::*;

    localparam logic [31:0] BLOCK_ERASE_CYC =
        32'(BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [31:0] FULL_ERASE_CYC =
        32'(FULL_ERASE_TIME_US * 1000 / CLK_PERIOD_NS);

    logic [2:0]   sync1_reg;
    logic [2:0]   sync2_reg;
    logic [1:0]   prev_reg;
    logic [11:0]  cnt_reg;
    logic [31:0]  sh_reg;
    logic [7:0]   op_reg;
    logic [7:0]   out_reg;
    logic         so_reg;
    logic         act_reg;
    logic         wip_reg;
    logic         wel_reg;
    logic [31:0]  ers_cnt_reg;
    logic [15:0]  dly_cnt_reg;
    logic         start_reg;
    logic [1:0]   kind_reg;
    logic [23:0]  base_reg;
    sfec_pwr_type pwr_reg;
    sfec_pwr_type pwr_next;
    logic [15:0]  dly_next;

    // two-stage synchronisers for select, clock and data in
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync1_reg[g] <= (g == 0) ? 1'b1 : 1'b0;
                    sync2_reg[g] <= (g == 0) ? 1'b1 : 1'b0;
                end else begin
                    sync1_reg[g] <= (g == 0) ? i_cs_n : (g == 1) ? i_sclk : i_si;
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate

    // edge detection on synchronised select and clock
    wire cs_n    = sync2_reg[0];
    wire sck     = sync2_reg[1];
    wire si      = sync2_reg[2];
    wire cs_rise = cs_n & ~prev_reg[0];
    wire sck_ris = ~cs_n & sck & ~prev_reg[1];
    wire sck_fal = ~cs_n & ~sck & prev_reg[1];

    // command classification
    wire end8    = cs_rise & (cnt_reg == OPCODE_BITS);
    wire end32   = cs_rise & (cnt_reg == ADDR_END);
    wire awake   = (pwr_reg == ST_AWAKE);
    wire asleep  = (pwr_reg == ST_ASLEEP) | (pwr_reg == ST_ENTERING);
    wire idle_ok = awake & ~wip_reg;
    wire is_32k  = (op_reg == OP_ERASE_32K);
    wire is_64k  = (op_reg == OP_ERASE_64K);
    wire is_chip = (op_reg == OP_CHIP_ERASE_A) | (op_reg == OP_CHIP_ERASE_B);
    wire [23:0] addr    = sh_reg[23:0];
    wire [23:0] blk_msk = is_32k ? BLK32_MASK : BLK64_MASK;
    wire [23:0] blk_bas = addr & ARRAY_MASK & blk_msk;
    wire [23:0] prot_lo = ARRAY_BYTES >> i_block_protect;
    wire [23:0] blk_top = blk_bas | (ARRAY_MASK & ~blk_msk);
    wire        blk_prt = (i_block_protect != 3'h0) & (blk_top >= prot_lo);
    wire        blk_go  = (is_32k | is_64k) & end32 & ~blk_prt;
    wire        chip_go = is_chip & end8 & (i_block_protect == 3'h0);
    wire        ers_go  = (blk_go | chip_go) & idle_ok & wel_reg;
    wire        write_enable_cmd_go = (op_reg == OP_WRITE_ENABLE) & end8 & idle_ok;
    wire        wrdi_go = (op_reg == OP_WRITE_DISABLE) & end8 & idle_ok;
    wire        dp_go   = (op_reg == OP_DEEP_SLEEP) & end8 & idle_ok;
    wire        wake_go = (op_reg == OP_WAKE_AND_ID) & cs_rise & asleep
                          & ~wip_reg & (cnt_reg >= OPCODE_BITS);
    wire        ers_end = wip_reg & (ers_cnt_reg == 32'h0000_0000);

    // which reading command may drive data out, and its first byte
    wire op_stat  = (op_reg == OP_READ_STATUS) & awake;
    wire op_wake  = (op_reg == OP_WAKE_AND_ID) & ~wip_reg
                    & (awake | asleep);
    wire op_maker = (op_reg == OP_MAKER_PART_ID) & idle_ok;
    wire op_three = (op_reg == OP_THREE_BYTE_ID) & idle_ok;
    wire op_uniq  = (op_reg == OP_UNIQUE_ID) & idle_ok;
    wire [8:0] first = op_stat ? STATUS_START : op_wake ? WAKE_ID_START :
                       op_maker ? MAKER_START : op_three ? THREE_START :
                       UNIQUE_START;
    wire rd_any  = op_stat | op_wake | op_maker | op_three | op_uniq;
    wire [8:0] idx   = cnt_reg[11:3] - first;
    wire       rd_on = rd_any & (cnt_reg[11:3] >= first) & (cnt_reg >= OPCODE_BITS);
    wire [127:0] uid_sh = UNIQUE_ID << {idx, 3'b000};
    wire [7:0] stat_b  = {3'b000, i_block_protect, wel_reg, wip_reg};
    wire [7:0] three_b = (idx == 9'h000) ? MAKER_ID :
                         (idx == 9'h001) ? MEM_TYPE :
                         (idx == 9'h002) ? CAPACITY : 8'h00;
    wire [7:0] maker_b = (idx[0] ^ addr[0]) ? PART_ID : MAKER_ID;
    wire [7:0] uniq_b  = (idx < 9'h010) ? uid_sh[127:120] : 8'h00;
    wire [7:0] byte_b  = op_stat ? stat_b : op_wake ? PART_ID :
                         op_maker ? maker_b : op_three ? three_b : uniq_b;

    // edge history and bit counter from select falling
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_reg <= 2'b01;
            cnt_reg  <= 12'h000;
        end else begin
            prev_reg <= {sck, cs_n};
            if (prev_reg[0])
                cnt_reg <= 12'h000;
            else if (sck_ris && cnt_reg != CNT_MAX)
                cnt_reg <= cnt_reg + 12'h001;
        end
    end

    // opcode and address shift in on rising clock, msb first
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sh_reg <= 32'h0000_0000;
            op_reg <= 8'h00;
        end else if (sck_ris && cnt_reg < ADDR_END) begin
            sh_reg <= {sh_reg[30:0], si};
            if (cnt_reg == OPCODE_BITS - 12'h001)
                op_reg <= {sh_reg[6:0], si};
        end
    end

    // output shifter: byte load on each boundary, shift on falling clock
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_reg <= 8'h00;
            so_reg  <= 1'b0;
            act_reg <= 1'b0;
        end else if (cs_n) begin
            act_reg <= 1'b0;
        end else if (sck_fal) begin
            act_reg <= rd_on;
            if (cnt_reg[2:0] == 3'h0) begin
                so_reg  <= byte_b[7];
                out_reg <= {byte_b[6:0], 1'b0};
            end else begin
                so_reg  <= out_reg[7];
                out_reg <= {out_reg[6:0], 1'b0};
            end
        end
    end

    // write enable latch and progress flag
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wel_reg <= 1'b0;
            wip_reg <= 1'b0;
        end else begin
            if (write_enable_cmd_go)
                wel_reg <= 1'b1;
            else if (wrdi_go || ers_go)
                wel_reg <= 1'b0;
            if (ers_go)
                wip_reg <= 1'b1;
            else if (ers_end)
                wip_reg <= 1'b0;
        end
    end

    // self-timed erase counter and erase target
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ers_cnt_reg <= 32'h0000_0000;
            start_reg   <= 1'b0;
            kind_reg    <= 2'h0;
            base_reg    <= 24'h00_0000;
        end else begin
            start_reg <= ers_go;
            if (ers_go) begin
                ers_cnt_reg <= is_chip ? FULL_ERASE_CYC : BLOCK_ERASE_CYC;
                kind_reg    <= is_chip ? KIND_CHIP : is_32k ? KIND_32K : KIND_64K;
                base_reg    <= is_chip ? 24'h00_0000 : blk_bas;
            end else if (wip_reg && ers_cnt_reg != 32'h0000_0000) begin
                ers_cnt_reg <= ers_cnt_reg - 32'h0000_0001;
            end
        end
    end

    // power state next value
    always_comb begin
        pwr_next = pwr_reg;
        dly_next = (dly_cnt_reg != 16'h0000) ? dly_cnt_reg - 16'h0001 : 16'h0000;
        unique case (pwr_reg)
            ST_AWAKE: begin
                if (dp_go) begin
                    pwr_next = ST_ENTERING;
                    dly_next = SLEEP_ENTRY_CYC;
                end
            end
            ST_ENTERING, ST_ASLEEP: begin
                if (wake_go) begin
                    pwr_next = ST_WAKING;
                    dly_next = (cnt_reg == OPCODE_BITS) ? WAKE_CYC : WAKE_ID_CYC;
                end else if (pwr_reg == ST_ENTERING && dly_cnt_reg == 16'h0000) begin
                    pwr_next = ST_ASLEEP;
                end
            end
            ST_WAKING: begin
                if (dly_cnt_reg == 16'h0000)
                    pwr_next = ST_AWAKE;
            end
        endcase
    end

    // power state, reset lands in standby
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_reg     <= ST_AWAKE;
            dly_cnt_reg <= 16'h0000;
        end else begin
            pwr_reg     <= pwr_next;
            dly_cnt_reg <= dly_next;
        end
    end

    // outputs
    assign o_so                     = so_reg;
    assign o_so_oe_n                = ~act_reg;
    assign o_write_in_progress_flag = wip_reg;
    assign o_write_enable_latch     = wel_reg;
    assign o_deep_sleep             = asleep;
    assign o_erase_start            = start_reg;
    assign o_erase_kind             = kind_reg;
    assign o_erase_base             = base_reg;

    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    property p_wip_start;
        o_erase_start |-> wip_reg ##1 (wip_reg || ers_end);
    endproperty
    a_wip_start: assert property (p_wip_start) else $error("no wip at erase");
    property p_wel_clear;
        ers_go |=> !wel_reg && wip_reg;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("wel kept");
    property p_blk_end32;
        (ers_go && !is_chip) |-> cnt_reg == ADDR_END && cs_rise;
    endproperty
    a_blk_end32: assert property (p_blk_end32) else $error("bad end");
    property p_protect;
        (ers_go && !is_chip) |-> !blk_prt;
    endproperty
    a_protect: assert property (p_protect) else $error("protected erase");
    property p_chip_bp;
        (o_erase_start && o_erase_kind == KIND_CHIP) |-> $past(i_block_protect) == 3'h0;
    endproperty
    a_chip_bp: assert property (p_chip_bp) else $error("chip erase protected");
    property p_align;
        (o_erase_start && o_erase_kind == KIND_32K) |-> o_erase_base[14:0] == 15'h0000;
    endproperty
    a_align: assert property (p_align) else $error("base not aligned");
    property p_sleep_hold;
        (pwr_reg == ST_ASLEEP && !wake_go) |=> pwr_reg == ST_ASLEEP && !wip_reg;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep");
    property p_busy_no_dp;
        (wip_reg && awake) |=> awake;
    endproperty
    a_busy_no_dp: assert property (p_busy_no_dp) else $error("sleep while busy");
    property p_busy_no_id;
        (wip_reg && op_reg == OP_WAKE_AND_ID) |=> o_so_oe_n;
    endproperty
    a_busy_no_id: assert property (p_busy_no_id) else $error("id while busy");
    property p_waking;
        (pwr_reg == ST_WAKING) |-> !ers_go && !write_enable_cmd_go && !dp_go;
    endproperty
    a_waking: assert property (p_waking) else $error("cmd while waking");
    property p_cs_ends;
        $rose(cs_n) |=> o_so_oe_n;
    endproperty
    a_cs_ends: assert property (p_cs_ends) else $error("drive after select");
endmodule // sfec_core
`default_nettype wire

// >>> verification/sfec_host.sv
/*
 * sfec_host: serial host model that frames commands for the flash core.
 * assumes the bench's 250 MHz clock; link clock idles low between frames.
 */
`timescale 1ns/100ps
`default_nettype none
module sfec_host (
    input  wire logic i_ref_clk,
    input  wire logic i_so,
    input  wire logic i_so_oe_n,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_si
);
    localparam int HALF = 20; // 80 ns half period of the link clock
    logic so_last = 1'b0;
    wire  so_line;
    // released data line shows the inverse of its last driven value
    always @(negedge i_ref_clk) begin
        if (!i_so_oe_n) so_last <= i_so;
    end
    assign so_line = i_so_oe_n ? ~so_last : i_so;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // one frame: n_out bits sent msb first, then n_in bits captured
    task automatic xfer(input int n_out, input logic [63:0] d, input int n_in,
                        output logic [127:0] q);
        q = '0;
        o_cs_n = 1'b0;
        gap(HALF);
        for (int i = 0; i < n_out + n_in; i++) begin
            o_si = (i < n_out) ? d[n_out-1-i] : ~o_si;
            gap(HALF);
            if (i >= n_out) q = {q[126:0], so_line}; // sampled at rise
            o_sclk = 1'b1;
            gap(HALF);
            o_sclk = 1'b0;
        end
        gap(HALF);
        o_cs_n = 1'b1;
        o_si = ~o_si; // line released
        gap(HALF);
    endtask
endmodule // sfec_host
`default_nettype wire

// >>> verification/tb_top.sv
/*
 * tb_top: self-checking bench for the flash erase, sleep and id logic.
 * assumes sfec_pkg and sfec_core; host model drives the serial link.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sfec_pkg::*;
    localparam logic [7:0]   MK  = 8'hC3; // arbitrary
    localparam logic [7:0]   PT  = 8'h3C; // arbitrary
    localparam logic [7:0]   MT  = 8'h71; // arbitrary
    localparam logic [7:0]   CP  = 8'h12; // arbitrary
    localparam logic [127:0] UID = 128'hA1B2_C3D4_E5F6_0718_293A_4B5C_6D7E_8F90; // arbitrary
    logic         ref_clk = 1'b0;
    logic         nrst = 1'b0;
    logic [2:0]   bp = 3'h0;
    logic         cs_n, sclk, si, so, so_oe_n, write_in_progress_flag, write_enable_latch, sleep, start;
    logic [1:0]   kind;
    logic [23:0]  base;
    logic [127:0] q;
    int           mismatches = 0;
    int           tests_run = 0;
    int           starts = 0;
    always #2 ref_clk = ~ref_clk;
    // erase start pulses counted
    always @(posedge ref_clk) begin
        if (start === 1'b1) starts <= starts + 1;
    end
    sfec_core #(.BLOCK_ERASE_TIME_US(16), .FULL_ERASE_TIME_US(8), .MAKER_ID(MK),
        .PART_ID(PT), .MEM_TYPE(MT), .CAPACITY(CP), .UNIQUE_ID(UID)) DUT (
        .i_ref_clk(ref_clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_si(si), .i_block_protect(bp), .o_so(so), .o_so_oe_n(so_oe_n),
        .o_write_in_progress_flag(write_in_progress_flag), .o_write_enable_latch(write_enable_latch),
        .o_deep_sleep(sleep), .o_erase_start(start), .o_erase_kind(kind),
        .o_erase_base(base));
    sfec_host host (.i_ref_clk(ref_clk), .i_so(so), .i_so_oe_n(so_oe_n),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));
    task automatic check(input string nm, input logic [127:0] seen,
                         input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic gap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cmd(input int n, input logic [63:0] d);
        host.xfer(n, d, 0, q);
    endtask
    // bounded wait for the erase cycle to end
    task automatic wait_idle;
        for (int n = 0; n < 5000 && write_in_progress_flag !== 1'b0; n++) gap(1);
        if (write_in_progress_flag !== 1'b0) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic erase_ok(input logic [1:0] k, input logic [23:0] b,
                            input int n, input logic [63:0] d);
        int s0;
        s0 = starts;
        cmd(n, d);
        check("start count", starts, s0 + 1);
        check("kind", kind, k);
        check("base", base, b);
        check("wel in cycle", write_enable_latch, 1'b0);
        check("wip in cycle", write_in_progress_flag, 1'b1);
    endtask
    task automatic refused(input int n, input logic [63:0] d);
        int s0;
        s0 = starts;
        cmd(n, d);
        check("no start", starts, s0);
        check("no wip", write_in_progress_flag, 1'b0);
    endtask
    task automatic t_erase64;
        bp = 3'h0;
        cmd(8, OP_WRITE_ENABLE);
        check("wel set", write_enable_latch, 1'b1);
        erase_ok(KIND_64K, 24'h01_0000, 32, {OP_ERASE_64K, 24'h01_2345});
        host.xfer(8, OP_READ_STATUS, 8, q);
        check("status", q, 8'h01);
        cmd(8, OP_DEEP_SLEEP);
        check("wip kept", write_in_progress_flag, 1'b1);
        // released line idles high here; any drive while busy would show
        host.xfer(8, OP_THREE_BYTE_ID, 8, q);
        check("id busy", q, 8'hFF);
        host.xfer(32, {OP_WAKE_AND_ID, 24'h00_0000}, 8, q);
        check("wake id busy", q, 8'hFF);
        check("wip after id", write_in_progress_flag, 1'b1);
        wait_idle();
        gap(800);
        check("no sleep", sleep, 1'b0);
        $display("done t_erase64");
    endtask
    task automatic t_refuse;
        refused(32, {OP_ERASE_32K, 24'h00_1000});
        cmd(8, OP_WRITE_ENABLE);
        refused(31, {OP_ERASE_32K, 24'h00_1000} >> 1);
        refused(33, {OP_ERASE_32K, 24'h00_1000, 1'b0});
        erase_ok(KIND_32K, 24'h00_8000, 32, {OP_ERASE_32K, 24'h00_ABCD});
        wait_idle();
        $display("done t_refuse");
    endtask
    task automatic t_protect;
        bp = 3'h1;
        cmd(8, OP_WRITE_ENABLE);
        refused(32, {OP_ERASE_64K, 24'h01_8000});
        refused(8, OP_CHIP_ERASE_A);
        bp = 3'h7;
        refused(32, {OP_ERASE_64K, 24'h00_0000});
        bp = 3'h1;
        erase_ok(KIND_32K, 24'h00_0000, 32, {OP_ERASE_32K, 24'h00_7FFF});
        wait_idle();
        bp = 3'h0;
        cmd(8, OP_WRITE_ENABLE);
        erase_ok(KIND_CHIP, 24'h00_0000, 8, OP_CHIP_ERASE_A);
        wait_idle();
        cmd(8, OP_WRITE_ENABLE);
        refused(9, {OP_CHIP_ERASE_B, 1'b0});
        erase_ok(KIND_CHIP, 24'h00_0000, 8, OP_CHIP_ERASE_B);
        wait_idle();
        $display("done t_protect");
    endtask
    task automatic t_sleep;
        cmd(9, {OP_DEEP_SLEEP, 1'b0});
        gap(800);
        check("sleep bad count", sleep, 1'b0);
        cmd(8, OP_DEEP_SLEEP);
        gap(800);
        check("asleep", sleep, 1'b1);
        cmd(8, OP_WRITE_ENABLE);
        check("wel asleep", write_enable_latch, 1'b0);
        cmd(8, OP_WAKE_AND_ID);
        cmd(8, OP_WRITE_ENABLE);
        check("wel waking", write_enable_latch, 1'b0);
        gap(800);
        check("awake", sleep, 1'b0);
        cmd(8, OP_WRITE_ENABLE);
        check("wel awake", write_enable_latch, 1'b1);
        cmd(8, OP_WRITE_DISABLE);
        cmd(8, OP_DEEP_SLEEP);
        gap(800);
        host.xfer(32, {OP_WAKE_AND_ID, 24'h00_0000}, 16, q);
        check("wake id", q, {PT, PT});
        gap(800);
        check("awake id", sleep, 1'b0);
        $display("done t_sleep");
    endtask
    task automatic t_ids;
        host.xfer(8, OP_THREE_BYTE_ID, 24, q);
        check("three id", q, {MK, MT, CP});
        host.xfer(8, OP_THREE_BYTE_ID, 8, q);
        check("short id", q, MK);
        check("oe off", so_oe_n, 1'b1);
        host.xfer(32, {OP_MAKER_PART_ID, 24'h00_0000}, 16, q);
        check("maker first", q, {MK, PT});
        host.xfer(32, {OP_MAKER_PART_ID, 24'h00_0001}, 16, q);
        check("part first", q, {PT, MK});
        host.xfer(40, {OP_UNIQUE_ID, 32'h0000_0000}, 128, q);
        check("unique id", q, UID);
        $display("done t_ids");
    endtask
    task automatic t_power;
        cmd(8, OP_DEEP_SLEEP);
        gap(800);
        check("asleep", sleep, 1'b1);
        nrst = 1'b0;
        gap(6);
        nrst = 1'b1;
        gap(4);
        check("standby", sleep, 1'b0);
        check("wel", write_enable_latch, 1'b0);
        $display("done t_power");
    endtask
    // reset, then every scenario in turn
    initial begin
        gap(6);
        nrst = 1'b1;
        gap(4);
        check("wip rst", write_in_progress_flag, 1'b0);
        check("sleep rst", sleep, 1'b0);
        check("oe rst", so_oe_n, 1'b1);
        t_erase64();
        t_refuse();
        t_protect();
        t_sleep();
        t_ids();
        t_power();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
